// file: logic/cdf_defs.vh
// constants for the clock divider fanout configuration block
`ifndef CDF_DEFS_VH
`define CDF_DEFS_VH
`define CDF_WORD_W      22
`define CDF_SEL_D_HI    21
`define CDF_SEL_C_HI    18
`define CDF_SEL_B_HI    15
`define CDF_SEL_A_HI    12
`define CDF_EN_HI       9
`define CDF_EN_LO       2
`define CDF_TYPE_BCD    1
`define CDF_TYPE_A      0
`define CDF_WORD_RESET  22'h000000
`define CDF_TYPE_LVDS   1'b0
`define CDF_CNT_W       3
`endif

// file: logic/cdf_bank_divider.v
// one bank divider: divides by a ratio from a 3-bit selector
`timescale 1ns/1ps
`include "cdf_defs.vh"
module cdf_bank_divider (
	input  wire       clk_i,
	input  wire       reset_n_i,
	input  wire       run_i,
	input  wire [2:0] sel_i,
	output reg        div_o
);
	reg  [2:0] cnt;
	reg  [3:0] ratio;
	wire [3:0] half_hi;
	always @* begin
		case ({sel_i[0], sel_i[1], sel_i[2]})
			3'h0: ratio = 4'h1;
			3'h1: ratio = 4'h2;
			3'h2: ratio = 4'h3;
			3'h3: ratio = 4'h4;
			3'h4: ratio = 4'h5;
			3'h5: ratio = 4'h6;
			3'h7: ratio = 4'h8;
			default: ratio = 4'h1;
		endcase
	end
	// high phase is the longer half on odd ratios
	assign half_hi = (ratio + 4'h1) >> 1;
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt   <= 3'h0;
			div_o <= 1'b0;
		end else if (!run_i) begin
			cnt   <= 3'h0;
			div_o <= 1'b0;
		end else if (ratio == 4'h1) begin
			div_o <= ~div_o;
		end else begin
			// first run cycle drives high, count 0 is high phase
			div_o <= ({1'b0, cnt} < half_hi);
			cnt   <= ({1'b0, cnt} == ratio - 4'h1) ? 3'h0 : cnt + 3'h1;
		end
	end
endmodule

// file: logic/cdf_config_top.v
// top of the clock divider fanout configuration block
`timescale 1ns/1ps
`include "cdf_defs.vh"
module cdf_config_top (
	input  wire       SYS_CLK_I,
	input  wire       RESET_N_I,
	input  wire       SERIAL_CLK_I,
	input  wire       SERIAL_DATA_IN_I,
	input  wire       LOAD_LATCH_STROBE_I,
	input  wire       OUTPUT_GATE_I,
	input  wire       DIVIDER_RESET_N_I,
	output reg        SERIAL_DATA_OUT_O,
	output reg  [1:0] BANK_A_OUTPUTS_O,
	output reg  [1:0] BANK_B_OUTPUTS_O,
	output reg  [1:0] BANK_C_OUTPUTS_O,
	output reg  [1:0] BANK_D_OUTPUTS_O,
	output reg  [1:0] BANK_A_ENABLED_O,
	output reg  [1:0] BANK_B_ENABLED_O,
	output reg  [1:0] BANK_C_ENABLED_O,
	output reg  [1:0] BANK_D_ENABLED_O,
	output reg        TYPE_BANK_A_O,
	output reg        TYPE_BANKS_BCD_O
);
	////////////////////////////////////////////////////////////////
	// pin synchronisers, a change counts once stages two and three agree
	reg  [2:0] s_sclk;
	reg  [2:0] s_sdat;
	reg  [2:0] s_le;
	reg  [2:0] s_oe;
	reg  [2:0] s_rst;
	reg        sclk_q;
	reg        sdat_q;
	reg        le_q;
	reg        oe_q;
	reg        rst_q;
	always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			s_sclk <= 3'h0;
			s_sdat <= 3'h0;
			s_le   <= 3'h0;
			s_oe   <= 3'h0;
			s_rst  <= 3'h0;
			sclk_q <= 1'b0;
			sdat_q <= 1'b0;
			le_q   <= 1'b0;
			oe_q   <= 1'b0;
			rst_q  <= 1'b0;
		end else begin
			s_sclk <= {s_sclk[1:0], SERIAL_CLK_I};
			s_sdat <= {s_sdat[1:0], SERIAL_DATA_IN_I};
			s_le   <= {s_le[1:0], LOAD_LATCH_STROBE_I};
			s_oe   <= {s_oe[1:0], OUTPUT_GATE_I};
			s_rst  <= {s_rst[1:0], DIVIDER_RESET_N_I};
			if (s_sclk[1] == s_sclk[2])
				sclk_q <= s_sclk[2];
			if (s_sdat[1] == s_sdat[2])
				sdat_q <= s_sdat[2];
			if (s_le[1] == s_le[2])
				le_q <= s_le[2];
			if (s_oe[1] == s_oe[2])
				oe_q <= s_oe[2];
			if (s_rst[1] == s_rst[2])
				rst_q <= s_rst[2];
		end
	end
	////////////////////////////////////////////////////////////////
	// serial shift register and active word
	reg                    sclk_d;
	reg                    le_d;
	reg                    loaded;
	reg [`CDF_WORD_W-1:0]  shift;
	reg [`CDF_WORD_W-1:0]  word;
	wire                   sclk_rise;
	wire                   le_rise;
	assign sclk_rise = sclk_q & ~sclk_d;
	assign le_rise   = le_q & ~le_d;
	// sampling slowed by the synchronisers: serial clock must stay at or under a quarter of the system clock, ~10 MHz at 40 MHz
	always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			sclk_d            <= 1'b0;
			le_d              <= 1'b0;
			loaded            <= 1'b0;
			shift             <= `CDF_WORD_RESET;
			word              <= `CDF_WORD_RESET;
			SERIAL_DATA_OUT_O <= 1'b0;
		end else begin
			sclk_d <= sclk_q;
			le_d   <= le_q;
			if (sclk_rise && !le_q) begin
				shift             <= {shift[`CDF_WORD_W-2:0], sdat_q};
				SERIAL_DATA_OUT_O <= shift[`CDF_WORD_W-1];
			end
			if (le_rise) begin
				word   <= shift;
				loaded <= 1'b1;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// dividers, released together by the divider reset
	wire       run;
	wire [3:0] div;
	wire [2:0] sel [0:3];
	assign run = rst_q & loaded;
	assign sel[0] = word[`CDF_SEL_A_HI:`CDF_SEL_A_HI-2];
	assign sel[1] = word[`CDF_SEL_B_HI:`CDF_SEL_B_HI-2];
	assign sel[2] = word[`CDF_SEL_C_HI:`CDF_SEL_C_HI-2];
	assign sel[3] = word[`CDF_SEL_D_HI:`CDF_SEL_D_HI-2];
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : bank
			cdf_bank_divider u_div (
				.clk_i     (SYS_CLK_I),
				.reset_n_i (RESET_N_I),
				.run_i     (run),
				.sel_i     (sel[g]),
				.div_o     (div[g])
			);
		end
	endgenerate
	////////////////////////////////////////////////////////////////
	// output gating and type selection
	wire [7:0] en_bits;
	wire [7:0] en_eff;
	assign en_bits = word[`CDF_EN_HI:`CDF_EN_LO];
	// gate pin and latch line dominate the serial enables
	assign en_eff = en_bits & {8{oe_q & le_q & loaded}};
	always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			BANK_A_OUTPUTS_O <= 2'h0;
			BANK_B_OUTPUTS_O <= 2'h0;
			BANK_C_OUTPUTS_O <= 2'h0;
			BANK_D_OUTPUTS_O <= 2'h0;
			BANK_A_ENABLED_O <= 2'h0;
			BANK_B_ENABLED_O <= 2'h0;
			BANK_C_ENABLED_O <= 2'h0;
			BANK_D_ENABLED_O <= 2'h0;
			TYPE_BANK_A_O    <= `CDF_TYPE_LVDS;
			TYPE_BANKS_BCD_O <= `CDF_TYPE_LVDS;
		end else begin
			BANK_A_ENABLED_O <= en_eff[1:0];
			BANK_B_ENABLED_O <= en_eff[3:2];
			BANK_C_ENABLED_O <= en_eff[5:4];
			BANK_D_ENABLED_O <= en_eff[7:6];
			// disabled outputs rest low
			BANK_A_OUTPUTS_O <= en_eff[1:0] & {2{div[0]}};
			BANK_B_OUTPUTS_O <= en_eff[3:2] & {2{div[1]}};
			BANK_C_OUTPUTS_O <= en_eff[5:4] & {2{div[2]}};
			BANK_D_OUTPUTS_O <= en_eff[7:6] & {2{div[3]}};
			// type only differs from lvds when the bank has a live output
			TYPE_BANK_A_O    <= word[`CDF_TYPE_A] & (|en_eff[1:0]);
			TYPE_BANKS_BCD_O <= word[`CDF_TYPE_BCD] & (|en_eff[7:2]);
		end
	end
endmodule

// file: verification/cdf_config_sva.sv
// checker of the configuration block outputs
`timescale 1ns/1ps
module cdf_config_sva (
	input wire       SYS_CLK_I,
	input wire       RESET_N_I,
	input wire       LOAD_LATCH_STROBE_I,
	input wire       OUTPUT_GATE_I,
	input wire       DIVIDER_RESET_N_I,
	input wire       SERIAL_DATA_OUT_O,
	input wire       TYPE_BANK_A_O,
	input wire       TYPE_BANKS_BCD_O,
	input wire [1:0] BANK_A_OUTPUTS_O,
	input wire [1:0] BANK_B_OUTPUTS_O,
	input wire [1:0] BANK_C_OUTPUTS_O,
	input wire [1:0] BANK_D_OUTPUTS_O,
	input wire [1:0] BANK_A_ENABLED_O,
	input wire [1:0] BANK_B_ENABLED_O,
	input wire [1:0] BANK_C_ENABLED_O,
	input wire [1:0] BANK_D_ENABLED_O
);
	wire [7:0] q = {BANK_D_OUTPUTS_O, BANK_C_OUTPUTS_O, BANK_B_OUTPUTS_O, BANK_A_OUTPUTS_O};
	wire [7:0] en = {BANK_D_ENABLED_O, BANK_C_ENABLED_O, BANK_B_ENABLED_O, BANK_A_ENABLED_O};
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	// pins pass a 3-flop sync plus agree: 6 cycles to the enables, 7 through the dividers
	a_gate_low_off: assert property ((!OUTPUT_GATE_I) [*6] |-> en == 8'h00) else $error("gate");
	a_latch_low_off: assert property ((!LOAD_LATCH_STROBE_I) [*6] |-> en == 8'h00) else $error("latch");
	a_off_is_quiet: assert property ((en == 8'h00) [*2] |-> q == 8'h00) else $error("quiet");
	a_type_a_lvds: assert property (en[1:0] == 2'h0 |-> !TYPE_BANK_A_O) else $error("type a");
	a_type_bcd_lvds: assert property (en[7:2] == 6'h00 |-> !TYPE_BANKS_BCD_O) else $error("type bcd");
	a_div_held: assert property ((!DIVIDER_RESET_N_I) [*7] |-> q == 8'h00) else $error("hold");
	a_start_aligned: assert property ((q == 8'h00 && $stable(en)) [*8] ##1 (q != 8'h00 && $stable(en))
		|-> q == en) else $error("start");
	a_reset_quiet: assert property ($rose(RESET_N_I) |-> q == 8'h00 && en == 8'h00) else $error("rst");
	a_readback_hold: assert property (LOAD_LATCH_STROBE_I [*8] |-> $stable(SERIAL_DATA_OUT_O)) else $error("sdo");
	c_all_high: cover property (q == 8'hff);
	c_gate_drop: cover property ($fell(OUTPUT_GATE_I));
	c_all_pecl: cover property (TYPE_BANK_A_O && TYPE_BANKS_BCD_O);
endmodule
bind cdf_config_top cdf_config_sva chk (.*);

// file: verification/cdf_host.sv
// host model driving the serial configuration pins
`timescale 1ns/1ps
module cdf_host (
	input  wire clk_i,
	output reg  sclk_o = 1'h0,
	output reg  sdat_o = 1'h0,
	output reg  latch_o = 1'h0
);
	// s sys cycles per serial phase, 5 at least
	task send(input [21:0] w, input integer s);
		integer i;
		begin
			latch_o = 1'h0;
			for (i = 21; i >= 0; i = i - 1) begin
				sdat_o = w[i];
				repeat (s) @(negedge clk_i);
				sclk_o = 1'h1;
				repeat (s) @(negedge clk_i);
				sclk_o = 1'h0;
			end
			sdat_o = 1'h0; // data line is driven low after the last bit
			repeat (s) @(negedge clk_i);
			latch_o = 1'h1;
		end
	endtask
endmodule

// file: verification/clock_divider_fanout_config_tb.sv
// bench: random words through the host model, checked outputs
`timescale 1ns/1ps
module clock_divider_fanout_config_tb;
	reg        SYS_CLK_I = 0, RESET_N_I = 0, OUTPUT_GATE_I = 0, DIVIDER_RESET_N_I = 0;
	wire       SERIAL_CLK_I, SERIAL_DATA_IN_I, LOAD_LATCH_STROBE_I, SERIAL_DATA_OUT_O, TYPE_BANK_A_O, TYPE_BANKS_BCD_O;
	wire [1:0] BANK_A_OUTPUTS_O, BANK_B_OUTPUTS_O, BANK_C_OUTPUTS_O, BANK_D_OUTPUTS_O;
	wire [1:0] BANK_A_ENABLED_O, BANK_B_ENABLED_O, BANK_C_ENABLED_O, BANK_D_ENABLED_O;
	wire [7:0] q = {BANK_D_OUTPUTS_O, BANK_C_OUTPUTS_O, BANK_B_OUTPUTS_O, BANK_A_OUTPUTS_O};
	wire [7:0] en = {BANK_D_ENABLED_O, BANK_C_ENABLED_O, BANK_B_ENABLED_O, BANK_A_ENABLED_O};
	reg [3:0]  last;
	reg [21:0] w, prev = 0;
	integer    err_total = 0, checks_done = 0, cyc = 0, i, n, t, r, rises [0:3];
	cdf_config_top dut (.*);
	cdf_host host (.clk_i(SYS_CLK_I), .sclk_o(SERIAL_CLK_I), .sdat_o(SERIAL_DATA_IN_I), .latch_o(LOAD_LATCH_STROBE_I));
	task chk(input [21:0] got, input [21:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks=%0d errors=%0d", checks_done, err_total);
			if (err_total == 0 && checks_done > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	initial forever #12.5 SYS_CLK_I = ~SYS_CLK_I;
	always @(posedge SYS_CLK_I) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			give_verdict;
		end
	end
	initial begin
		r = $urandom(32'h0e7e);
		repeat (8) @(negedge SYS_CLK_I);
		RESET_N_I = 1;
		OUTPUT_GATE_I = 1;
		repeat (8) @(negedge SYS_CLK_I);
		chk({TYPE_BANK_A_O, TYPE_BANKS_BCD_O, en, q}, 0);
		for (n = 0; n < 6; n = n + 1) begin
			w = $urandom;
			w[1:0] = n[1:0]; // every type pair
			if (n == 0) w[9:2] = 8'hff;
			for (i = 0; i < 4; i = i + 1)
				if (w[10+3*i +: 3] == 3'h3) w[12+3*i] = 1'h1;
			DIVIDER_RESET_N_I = 0;
			host.send(w, 5 + n);
			chk(SERIAL_DATA_OUT_O, prev[0]);
			prev = w;
			OUTPUT_GATE_I = 1;
			repeat (10) @(negedge SYS_CLK_I);
			chk({TYPE_BANK_A_O, TYPE_BANKS_BCD_O, en, q}, {w[0] & |w[3:2], w[1] & |w[9:4], w[9:2], 8'h00});
			DIVIDER_RESET_N_I = 1;
			t = 0;
			while (q == 0 && t < 20) begin
				@(negedge SYS_CLK_I);
				t = t + 1;
			end
			chk(q, en);
			last = 4'hf;
			for (i = 0; i < 4; i = i + 1) rises[i] = 0;
			// 240 cycles hold a whole number of periods of every ratio
			repeat (240) begin
				@(negedge SYS_CLK_I);
				for (i = 0; i < 4; i = i + 1) if (|q[2*i +: 2] && !last[i]) rises[i] = rises[i] + 1;
				last = {|q[7:6], |q[5:4], |q[3:2], |q[1:0]};
			end
			for (i = 0; i < 4; i = i + 1) begin
				t = {w[10+3*i], w[11+3*i], w[12+3*i]};
				r = (t == 7) ? 8 : t + 1;
				chk(rises[i], |w[2+2*i +: 2] ? ((r == 1) ? 120 : 240 / r) : 0);
			end
			OUTPUT_GATE_I = 0;
			repeat (6) @(negedge SYS_CLK_I);
			chk({TYPE_BANK_A_O, TYPE_BANKS_BCD_O, en, q}, 0);
		end
		give_verdict;
	end
endmodule
